// ### logic/smi_ctl.sv
// Purpose: legacy smi enable/status register with axi4-lite slave
// Assumes: host status flags and legacy events arrive as same-clock pulses
// Notes: host shadow status bits are read-only, cleared via host status word; legacy bits 31:29 clear by write-one
`timescale 1ns/10ps

// Overview of operation
// - transfer-complete smi status is read-only, mirrors host transfer_complete_irq_flag
// - bar enable bit 15 with bar status raises smi
// - pci command enable with pci command status raises smi
// - ownership enable with ownership change status raises smi
// - async advance enable bit 5 with status raises smi one cycle after the status bit sets
// - host system error enable bit 4 with status raises smi
// - frame list rollover enable bit 3 with status raises smi
// - port change enable bit 2 with status raises smi
// - transfer error enable bit 1 with status raises smi one cycle after the status bit sets
// - transfer complete enable bit 0 with status raises smi one cycle after the status bit sets
// - rollover status mirrors host flag, cleared through that flag
// - port change status mirrors host flag, cleared through that flag
// - transfer error status mirrors transfer_error_irq_flag, cleared through it
module smi_ctl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] host_evt,
  input wire logic bar_evt,
  input wire logic pci_cmd_evt,
  input wire logic os_own_evt,
  output logic smi_req,
  output logic irq
);
  // ==========================================================================
  // write channel capture
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic awready_q;
  logic wready_q;
  logic arready_q;
  // take only while ready stands, so a held request never lands twice
  wire aw_take = s_axi_awvalid && awready_q;
  wire w_take = s_axi_wvalid && wready_q;
  wire wr_go = aw_full_q && w_full_q && !bvalid_q;
  wire sel_ctl = wr_go && aw_addr_q == smi_pkg::ctl_sts_off;
  wire sel_irqs = wr_go && aw_addr_q == smi_pkg::irq_sts_off;
  wire sel_mask = wr_go && aw_addr_q == smi_pkg::irq_mask_off;
  wire sel_host = wr_go && aw_addr_q == smi_pkg::host_sts_off;
  wire wr_hit = sel_ctl || sel_irqs || sel_mask || sel_host;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr[7:0];
      end else if (wr_go) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= smi_pkg::resp_okay;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? smi_pkg::resp_okay : smi_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  // ==========================================================================
  // byte-lane write masks
  wire [31:0] lane = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wmask = w_data_q & lane;
  // ==========================================================================
  // enables; status half takes no writes here, ones in bits 31:29 clear the legacy bits
  logic [15:0] en_q;
  wire [15:0] en_d = (en_q & ~lane[15:0]) | (wmask[15:0] & smi_pkg::en_mask);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= smi_pkg::en_reset;
    end else if (sel_ctl) begin
      en_q <= en_d;
    end
  end
  // ==========================================================================
  // host status flags: the only place the six host shadow bits are cleared
  logic [5:0] host_q;
  wire [5:0] host_clr = sel_host ? wmask[5:0] : 6'h00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_q <= 6'h00;
    end else begin
      // set wins over a clear in the same cycle
      host_q <= (host_q & ~host_clr) | host_evt;
    end
  end
  // ==========================================================================
  // legacy status bits (bar, pci command, ownership) cleared by write-one
  logic [2:0] leg_q;
  wire [2:0] leg_evt = {bar_evt, pci_cmd_evt, os_own_evt};
  wire [2:0] leg_clr = sel_ctl ? wmask[31:29] : 3'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      leg_q <= 3'h0;
    end else begin
      leg_q <= (leg_q & ~leg_clr) | leg_evt;
    end
  end
  // ==========================================================================
  // shadow status word, wired straight from host flags and legacy status bits
  wire [15:0] sts_w;
  assign sts_w[smi_pkg::en_xfer_done] = host_q[0];
  assign sts_w[smi_pkg::en_xfer_err] = host_q[1];
  assign sts_w[smi_pkg::en_port_chg] = host_q[2];
  assign sts_w[smi_pkg::en_flr] = host_q[3];
  assign sts_w[smi_pkg::en_host_err] = host_q[4];
  assign sts_w[smi_pkg::en_async_adv] = host_q[5];
  assign sts_w[12:6] = 7'h00;
  assign sts_w[15:13] = leg_q;
  wire [31:0] ctl_word = {sts_w, en_q};
  // ==========================================================================
  // smi combination
  smi_gate_if gi ();
  // pairwise and
  assign gi.sts = sts_w;
  assign gi.en = en_q;
  smi_gate u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .g(gi.gate)
  );
  // ==========================================================================
  // interrupt: rising smi request sets a sticky bit, plus any write error
  logic [1:0] irq_sts_q;
  logic [1:0] irq_mask_q;
  logic req_prev_q;
  logic irq_q;
  wire [1:0] irq_evt = {wr_go && !wr_hit, gi.req && !req_prev_q};
  wire [1:0] irq_clr = sel_irqs ? wmask[1:0] : 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_q <= smi_pkg::irq_reset;
      irq_mask_q <= smi_pkg::irq_reset;
      req_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_evt;
      if (sel_mask) begin
        irq_mask_q <= (irq_mask_q & ~lane[1:0]) | wmask[1:0];
      end
      req_prev_q <= gi.req;
      irq_q <= |(irq_sts_q & irq_mask_q);
    end
  end
  // ==========================================================================
  // read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire ar_take = s_axi_arvalid && arready_q;
  wire [7:0] ra = s_axi_araddr[7:0];
  wire rd_hit = ra == smi_pkg::ctl_sts_off || ra == smi_pkg::irq_sts_off ||
                ra == smi_pkg::irq_mask_off || ra == smi_pkg::host_sts_off;
  wire [31:0] rd_mux = (ra == smi_pkg::ctl_sts_off) ? ctl_word :
                       (ra == smi_pkg::irq_sts_off) ? {30'h0, irq_sts_q} :
                       (ra == smi_pkg::irq_mask_off) ? {30'h0, irq_mask_q} :
                       (ra == smi_pkg::host_sts_off) ? {26'h0, host_q} : 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= smi_pkg::resp_okay;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? smi_pkg::resp_okay : smi_pkg::resp_slverr;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  // ==========================================================================
  // output registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      // ready one cycle ahead; slot frees only after the pulse is used
      awready_q <= !aw_full_q && !bvalid_q && !aw_take && !wr_go;
      wready_q <= !w_full_q && !bvalid_q && !w_take && !wr_go;
      arready_q <= !rvalid_q && !ar_take;
    end
  end
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign smi_req = gi.req;
  assign irq = irq_q;
endmodule : smi_ctl

// ### logic/smi_gate.sv
// Purpose: combine enabled status bits into one smi request
// Assumes: status and enables sampled on aclk
// Notes: registered request, one cycle after cause
`timescale 1ns/10ps
module smi_gate (
  input wire logic aclk,
  input wire logic aresetn,
  smi_gate_if.gate g
);
  // ==========================================================================
  // gating
  wire [15:0] hits = g.sts & g.en;
  wire any_hit = |hits;
  logic req_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= 1'b0;
    end else begin
      req_q <= any_hit; // no frame wait, next edge
    end
  end
  assign g.req = req_q;
endmodule : smi_gate

// ### logic/smi_gate_if.sv
// Purpose: status and enable pair carried to the smi gate
// Assumes: single clock
// Notes: none
`timescale 1ns/10ps
interface smi_gate_if;
  logic [15:0] sts;
  logic [15:0] en;
  logic req;
  modport ctl (output sts, output en, input req);
  modport gate (input sts, input en, output req);
endinterface : smi_gate_if

// ### logic/smi_pkg.sv
// Purpose: constants for the legacy smi control/status block
// Assumes: 32-bit axi4-lite register bus, one aligned word per register
// Notes: status half in bits 31:16, enables in bits 15:0
package smi_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] ctl_sts_off = 8'h00;
  localparam logic [7:0] irq_sts_off = 8'h04;
  localparam logic [7:0] irq_mask_off = 8'h08;
  localparam logic [7:0] host_sts_off = 8'h0c;
  // ==========================================================================
  // field positions (enable bit n pairs with status bit n+16)
  localparam int sts_base = 16;
  localparam int en_bar = 15;
  localparam int en_pci_cmd = 14;
  localparam int en_os_own = 13;
  localparam int en_async_adv = 5;
  localparam int en_host_err = 4;
  localparam int en_flr = 3;
  localparam int en_port_chg = 2;
  localparam int en_xfer_err = 1;
  localparam int en_xfer_done = 0;
  // writable enables
  localparam logic [15:0] en_mask = 16'he03f;
  // host status flags (write one to clear), low six bits
  localparam int hs_width = 6;
  // ==========================================================================
  // reset values and response codes
  localparam logic [15:0] en_reset = 16'h0000;
  localparam logic [1:0] irq_reset = 2'h0;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : smi_pkg

// ### verification/ehci_legacy_smi_enable_logic_tb_top.sv
// Purpose: self-checking bench of the smi control block
// Assumes: axi4-lite master held by non-blocking drives
// Notes: random enables and events with hand-picked corners
`timescale 1ns/10ps
module ehci_legacy_smi_enable_logic_tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [5:0] host_evt = 6'h0;
  logic bar_evt = 1'h0, pci_cmd_evt = 1'h0, os_own_evt = 1'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic smi_req, irq;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int failures = 0;
  int num_checks = 0;
  always #4 aclk = ~aclk;
  smi_ctl u_smi_ctl (.*);
  // ==========================================================================
  // tasks
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (n > 50) begin
        failures++;
        conclude();
      end
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (n > 50) begin
        failures++;
        conclude();
      end
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    if (er == smi_pkg::resp_okay) check("rdata", s_axi_rdata, e);
  endtask : rd
  task automatic fire(input logic [5:0] h, input logic [2:0] l);
    @(posedge aclk);
    host_evt <= h;
    {bar_evt, pci_cmd_evt, os_own_evt} <= l;
    @(posedge aclk);
    host_evt <= 6'h0;
    {bar_evt, pci_cmd_evt, os_own_evt} <= 3'h0;
    tick(4);
  endtask : fire
  function automatic logic [31:0] word(logic [5:0] h, logic [2:0] l, logic [15:0] en);
    return {l, 7'h0, h, en & smi_pkg::en_mask};
  endfunction : word
  function automatic logic [31:0] smi(logic [31:0] w);
    return {31'h0, |(w[31:16] & w[15:0])};
  endfunction : smi
  // ==========================================================================
  // main sequence
  initial begin
    logic [5:0] h;
    logic [2:0] l;
    logic [15:0] en;
    void'($urandom(32'haff50ed7));
    tick(8);
    aresetn <= 1'h1;
    tick(2);
    rd(smi_pkg::ctl_sts_off, 32'h0, smi_pkg::resp_okay);
    wr(smi_pkg::irq_mask_off, 32'h1, smi_pkg::resp_okay);
    rd(8'h20, 32'h0, smi_pkg::resp_slverr);
    wr(8'h24, 32'hffffffff, smi_pkg::resp_slverr);
    tick(3);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(smi_pkg::irq_mask_off, 32'h3, smi_pkg::resp_okay);
    tick(3);
    check("irq", {31'h0, irq}, 32'h1);
    wr(smi_pkg::irq_sts_off, 32'h2, smi_pkg::resp_okay);
    tick(3);
    check("irq clr", {31'h0, irq}, 32'h0);
    // byte lanes: upper lane first, then lower lane, status half untouched
    s_axi_wstrb <= 4'h2;
    wr(smi_pkg::ctl_sts_off, 32'hffff_ffff, smi_pkg::resp_okay);
    rd(smi_pkg::ctl_sts_off, 32'h0000_e000, smi_pkg::resp_okay);
    s_axi_wstrb <= 4'h1;
    wr(smi_pkg::ctl_sts_off, 32'hffff_ffff, smi_pkg::resp_okay);
    rd(smi_pkg::ctl_sts_off, 32'h0000_e03f, smi_pkg::resp_okay);
    s_axi_wstrb <= 4'hf;
    for (int i = 0; i < 16; i++) begin
      h = 6'($urandom);
      l = 3'($urandom);
      en = 16'($urandom);
      if (i == 0) {h, l, en} = {9'h0, 16'hffff};
      if (i == 1) {h, l, en} = {9'h1ff, 16'h0};
      if (i == 2) {h, l, en} = {9'h1ff, 16'hffff};
      wr(smi_pkg::ctl_sts_off, {16'h0, en}, smi_pkg::resp_okay);
      fire(h, l);
      rd(smi_pkg::ctl_sts_off, word(h, l, en), smi_pkg::resp_okay);
      check("smi", {31'h0, smi_req}, smi(word(h, l, en)));
      wr(smi_pkg::ctl_sts_off, {16'hffff, en}, smi_pkg::resp_okay);
      tick(3);
      rd(smi_pkg::ctl_sts_off, word(h, 3'h0, en), smi_pkg::resp_okay);
      check("smi kept", {31'h0, smi_req}, smi(word(h, 3'h0, en)));
      wr(smi_pkg::host_sts_off, {26'h0, h}, smi_pkg::resp_okay);
      tick(3);
      rd(smi_pkg::ctl_sts_off, word(6'h0, 3'h0, en), smi_pkg::resp_okay);
      check("smi off", {31'h0, smi_req}, 32'h0);
    end
    rd(smi_pkg::irq_sts_off, 32'h1, smi_pkg::resp_okay);
    wr(smi_pkg::irq_sts_off, 32'h3, smi_pkg::resp_okay);
    tick(3);
    check("irq end", {31'h0, irq}, 32'h0);
    // mid-run reset with enables still set from the last round
    aresetn <= 1'h0;
    tick(3);
    aresetn <= 1'h1;
    tick(2);
    rd(smi_pkg::ctl_sts_off, 32'h0, smi_pkg::resp_okay);
    rd(smi_pkg::irq_mask_off, 32'h0, smi_pkg::resp_okay);
    check("smi after reset", {31'h0, smi_req}, 32'h0);
    conclude();
  end
endmodule : ehci_legacy_smi_enable_logic_tb_top

// ### verification/smi_ctl_sva.sv
// Purpose: port-level checks of the smi control block
// Assumes: one clock, sync active-low reset
// Notes: ages saturate, so a long quiet spell stays legal
`timescale 1ns/10ps
module smi_ctl_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] host_evt,
  input wire logic bar_evt,
  input wire logic pci_cmd_evt,
  input wire logic os_own_evt,
  input wire logic smi_req,
  input wire logic irq
);
  // ==========================================================================
  // ages since last write beat or event
  logic [3:0] ev_age_q;
  logic [3:0] wr_age_q;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic ev_any = w_take || (|host_evt) || bar_evt || pci_cmd_evt || os_own_evt;
  always_ff @(posedge aclk) begin
    ev_age_q <= (!aresetn || ev_any) ? 4'h0 : ev_age_q + {3'h0, ev_age_q != 4'hf};
    wr_age_q <= (!aresetn || w_take) ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hf};
  end
  // ==========================================================================
  // properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_quiet; $rose(aresetn) |-> (!smi_req && !irq) [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("smi or irq after reset");
  property p_rise; $rose(smi_req) |-> ev_age_q < 4'h5; endproperty
  a_rise: assert property (p_rise) else $error("smi rose without cause");
  property p_fall; $fell(smi_req) |-> wr_age_q < 4'h6; endproperty
  a_fall: assert property (p_fall) else $error("smi fell without write");
  property p_rd; s_ar_take |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_wr; w_take |-> ##[1:4] s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_unmap; s_ar_take ##0 s_axi_araddr > 32'hc |=> s_axi_rresp == smi_pkg::resp_slverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  // ready may stand while idle; it must drop once an address is taken
  property p_rdy; s_axi_awready && s_axi_awvalid |=> !s_axi_awready; endproperty
  a_rdy: assert property (p_rdy) else $error("awready stayed after a take");
  property p_arrdy; s_ar_take |=> !s_axi_arready; endproperty
  a_arrdy: assert property (p_arrdy) else $error("arready stayed after a take");
endmodule : smi_ctl_sva
bind smi_ctl smi_ctl_sva u_smi_ctl_sva (.*);
